// file: logic/scan_irq_ctrl.sv
// Interrupt, trigger and status logic of the converter scan sequencer
//
// Behaviour
// - Scan completion raises scan done flag
// - Main masked view is flags AND mask
// - Force write sets main flags directly
// - Writing one to flag bit clears it
// - Completion with done still set flags overrun
// - Busy trigger waits, never aborts scan
// - Non-continuous busy trigger sets clash flags
// - Range check on each finished result
// - Masked range flags drive interrupt output
// - Range force sets flags; reads show flags
// - Sixteen range flags plus injected one
// - Raw min/max code sets clip flag immediately
// - Masked clip flags drive interrupt output
// - Cause mirrors main masked plus two ORs
// - Sw request starts scan, cleared at completion
// - Disabling block clears sw request at once
// - Peripheral triggers also start scans
// - Continuous mode rescans, ignores other triggers
// - Idle trigger starts sampling next cycle
// - Status shows busy and active channel
// - Status shows live negative-reference switch
// - Averaging accumulator and down counter exposed
// - Mux switch state mirrors firmware switches
`timescale 1ns/1ps
`include "scan_irq_regs.svh"
module scan_irq_ctrl (
  input  wire logic                              mclk_i,
  input  wire logic                              rst_n_i,
  // Block enable and scan setup
  input  wire logic                              enable_i,
  input  wire logic                              continuous_i,
  input  wire logic                              sw_scan_request_wr_i,
  input  wire logic                              periph_trigger_i,
  // Converter datapath events
  input  wire logic                              start_ack_i,
  input  wire logic                              scan_complete_i,
  input  wire logic                              converting_i,
  input  wire logic [`CHAN_W-1:0]                chan_now_i,
  input  wire scan_irq_pkg::sample_evt_t         sample_i,
  input  wire scan_irq_pkg::result_evt_t         result_i,
  input  wire scan_irq_pkg::window_cfg_t         window_cfg_i,
  input  wire scan_irq_pkg::averaging_progress_t avg_i,
  input  wire logic                              neg_ref_sw_i,
  input  wire logic [`SWITCH_W-1:0]              fw_mux_switches_i,
  // Software flag controls: write-one clear and force pulses, level masks
  input  wire scan_irq_pkg::main_vec_t           main_irq_clear_i,
  input  wire scan_irq_pkg::main_vec_t           main_irq_force_i,
  input  wire scan_irq_pkg::main_vec_t           main_irq_mask_i,
  input  wire scan_irq_pkg::chan_vec_t           window_irq_clear_i,
  input  wire scan_irq_pkg::chan_vec_t           window_irq_force_i,
  input  wire scan_irq_pkg::chan_vec_t           window_irq_mask_i,
  input  wire scan_irq_pkg::chan_vec_t           clip_irq_clear_i,
  input  wire scan_irq_pkg::chan_vec_t           clip_irq_force_i,
  input  wire scan_irq_pkg::chan_vec_t           clip_irq_mask_i,
  input  wire logic                              inj_window_clear_i,
  input  wire logic                              inj_window_force_i,
  input  wire logic                              inj_clip_clear_i,
  input  wire logic                              inj_clip_force_i,
  // Scan start command and software-visible state
  output logic                                   start_sampling_o,
  output logic                                   sw_scan_request_o,
  output scan_irq_pkg::main_vec_t                main_irq_flags_o,
  output scan_irq_pkg::main_vec_t                main_irq_masked_o,
  output scan_irq_pkg::chan_vec_t                window_hit_flags_o,
  output scan_irq_pkg::chan_vec_t                window_irq_masked_o,
  output scan_irq_pkg::chan_vec_t                clip_flags_o,
  output scan_irq_pkg::chan_vec_t                clip_irq_masked_o,
  output logic                                   injected_window_hit_flag_o,
  output logic                                   injected_clip_flag_o,
  output logic [`MAIN_FLAGS+1:0]                 irq_source_summary_o,
  output logic                                   irq_o,
  output scan_irq_pkg::sequencer_state_t         sequencer_state_o,
  output scan_irq_pkg::averaging_progress_t      averaging_progress_o,
  output logic [`SWITCH_W-1:0]                   mux_switch_state_o
);
  import scan_irq_pkg::*;

  // Sequencer state
  seq_state_t state_q;     // Scan state
  seq_state_t state_d;
  logic       pend_q;      // Trigger queued behind a running scan
  logic       pend_d;
  logic       sw_req_q;    // Software scan request bit
  logic       sw_req_d;
  logic       start_q;     // Start command to converter
  logic       start_d;

  // Event pulses computed from the sequencer
  logic       trig_any;    // Any non-continuous trigger this cycle
  logic       done_evt;    // Scan finished this cycle
  main_vec_t  main_set;    // Hardware sets for main flags
  chan_vec_t  win_set;     // Hardware sets for range flags
  chan_vec_t  clip_set;    // Hardware sets for clip flags
  logic       inj_win_set;
  logic       inj_clip_set;
  logic       win_hit;     // Current result lies in the chosen window

  // Flag banks
  main_vec_t  main_flags;
  main_vec_t  main_masked;
  chan_vec_t  win_flags;
  chan_vec_t  win_masked;
  chan_vec_t  clip_flags;
  chan_vec_t  clip_masked;
  // Bit 0 injected range, bit 1 injected clip
  logic [1:0] inj_flags;

  // Status registers
  logic [`MAIN_FLAGS+1:0] cause_q;
  logic [`MAIN_FLAGS+1:0] cause_d;
  logic                   irq_q;
  logic                   irq_d;
  sequencer_state_t       stat_q;
  sequencer_state_t       stat_d;
  averaging_progress_t    avg_q;
  logic [`SWITCH_W-1:0]   mux_q;

  // Triggers that can queue or clash
  assign trig_any = periph_trigger_i | sw_scan_request_wr_i;
  // Completion counts only while busy
  assign done_evt = (state_q == SEQ_BUSY) & scan_complete_i;

  // Scan sequencer next state
  always_comb begin
    state_d  = state_q;
    pend_d   = pend_q;
    sw_req_d = sw_req_q | sw_scan_request_wr_i;
    start_d  = 1'b0;
    case (state_q)
      SEQ_IDLE: begin
        // Idle trigger starts on the next edge;
        // so does one queued at completion
        if (enable_i && (trig_any || continuous_i || pend_q)) begin
          state_d = SEQ_START;
          start_d = 1'b1;
          pend_d  = 1'b0;
        end
      end
      SEQ_START: begin
        // Hold start until the converter accepts it
        start_d = ~start_ack_i;
        if (start_ack_i) begin
          state_d = SEQ_BUSY;
        end
        // Queue is one deep
        if (trig_any && !continuous_i) begin
          pend_d = 1'b1;
        end
      end
      SEQ_BUSY: begin
        // A trigger here is queued, the scan runs on
        if (trig_any && !continuous_i) begin
          pend_d = 1'b1;
        end
        if (scan_complete_i) begin
          // A write at completion stays
          sw_req_d = sw_scan_request_wr_i;
          if (continuous_i || pend_q) begin
            // Queued or continuous scan starts straight away
            state_d = SEQ_START;
            start_d = 1'b1;
            pend_d  = 1'b0;
          end else begin
            state_d = SEQ_IDLE;
          end
        end
      end
      default: begin
        state_d = SEQ_IDLE;
      end
    endcase
    // Disable drops the request at once and parks the sequencer
    if (!enable_i) begin
      sw_req_d = 1'b0;
      // Nothing stays queued
      pend_d   = 1'b0;
      state_d  = SEQ_IDLE;
      start_d  = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q  <= SEQ_IDLE;
      pend_q   <= 1'b0;
      sw_req_q <= 1'b0;
      start_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      pend_q   <= pend_d;
      sw_req_q <= sw_req_d;
      start_q  <= start_d;
    end
  end

  // Window comparison on the finished, formatted result
  // Unsigned compare: offset signed thresholds
  always_comb begin
    case (window_cfg_i.cond)
      `COND_BELOW:  win_hit = result_i.value < window_cfg_i.low;
      `COND_INSIDE: win_hit = (result_i.value >= window_cfg_i.low) &&
                              (result_i.value <  window_cfg_i.high);
      `COND_ABOVE:  win_hit = result_i.value >= window_cfg_i.high;
      `COND_OUTSIDE: win_hit = (result_i.value < window_cfg_i.low) ||
                               (result_i.value >= window_cfg_i.high);
      default:      win_hit = 1'b0;
    endcase
  end

  // Hardware event sets for every flag bank
  always_comb begin
    main_set = '0;
    main_set[`BIT_DONE]    = done_evt;
    // Overrun when done flag still up; results get overwritten
    main_set[`BIT_OVERRUN] = done_evt & main_flags[`BIT_DONE];
    // Clash only for non-continuous triggers during a scan
    main_set[`BIT_CLASH]   = (state_q != SEQ_IDLE) & trig_any &
                             ~continuous_i & enable_i;
    // Firmware write also marks its own bit
    main_set[`BIT_SW_CLASH] = (state_q != SEQ_IDLE) &
                              sw_scan_request_wr_i &
                              ~continuous_i & enable_i;
    // Range per result, without waiting for scan end
    win_set = '0;
    win_set[result_i.chan] = result_i.valid & ~result_i.injected &
                             win_hit;
    inj_win_set = result_i.valid & result_i.injected & win_hit;
    // Clip checks the raw code before averaging
    clip_set = '0;
    clip_set[sample_i.chan] = sample_i.valid & ~sample_i.injected &
                              ((sample_i.code == `CODE_MIN) ||
                               (sample_i.code == `CODE_MAX));
    inj_clip_set = sample_i.valid & sample_i.injected &
                   ((sample_i.code == `CODE_MIN) ||
                    (sample_i.code == `CODE_MAX));
  end

  // Main flags: write-one clear, force, set beats clear
  // Long clear pulses clear every cycle
  sticky_flags #(.W(`MAIN_FLAGS)) u_main (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .hw_set_i (main_set),
    .force_i  (main_irq_force_i),
    .clear_i  (main_irq_clear_i),
    .mask_i   (main_irq_mask_i),
    .flags_o  (main_flags),
    .masked_o (main_masked)
  );

  // Per-channel range flags
  sticky_flags #(.W(`NUM_CHAN)) u_window (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .hw_set_i (win_set),
    .force_i  (window_irq_force_i),
    .clear_i  (window_irq_clear_i),
    .mask_i   (window_irq_mask_i),
    .flags_o  (win_flags),
    .masked_o (win_masked)
  );

  // Per-channel clip flags
  sticky_flags #(.W(`NUM_CHAN)) u_clip (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .hw_set_i (clip_set),
    .force_i  (clip_irq_force_i),
    .clear_i  (clip_irq_clear_i),
    .mask_i   (clip_irq_mask_i),
    .flags_o  (clip_flags),
    .masked_o (clip_masked)
  );

  // Injected channel flags; they have no mask of their own
  sticky_flags #(.W(2)) u_inj (
    .mclk_i   (mclk_i),
    .rst_n_i  (rst_n_i),
    .hw_set_i ({inj_clip_set, inj_win_set}),
    .force_i  ({inj_clip_force_i, inj_window_force_i}),
    .clear_i  ({inj_clip_clear_i, inj_window_clear_i}),
    .mask_i   (2'h0),
    .flags_o  (inj_flags),
    .masked_o ()
  );

  // Cause summary and interrupt line from the registered masked views
  // Injected flags stay out of both
  always_comb begin
    cause_d = {|clip_masked, |win_masked, main_masked};
    irq_d   = (|main_masked) | (|win_masked) | (|clip_masked);
  end

  // Status capture; busy covers sampling and converting
  // Status lags one cycle; firmware polls
  always_comb begin
    stat_d.busy = (state_q != SEQ_IDLE) | converting_i;
    stat_d.active_channel_index    = chan_now_i;
    stat_d.neg_to_ref_switch_state = neg_ref_sw_i;
  end

  // Status and summary registers; one cycle behind their sources
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cause_q <= '0;
      irq_q   <= 1'b0;
      stat_q  <= '0;
      avg_q   <= '0;
      mux_q   <= '0;
    end else begin
      cause_q <= cause_d;
      irq_q   <= irq_d;
      stat_q  <= stat_d;
      avg_q   <= avg_i;
      mux_q   <= fw_mux_switches_i;
    end
  end

  // Outputs: flops only, so the line never
  // glitches into the interrupt controller
  assign start_sampling_o           = start_q;
  assign sw_scan_request_o          = sw_req_q;
  assign main_irq_flags_o           = main_flags;
  assign main_irq_masked_o          = main_masked;
  assign window_hit_flags_o         = win_flags;
  assign window_irq_masked_o        = win_masked;
  assign clip_flags_o               = clip_flags;
  assign clip_irq_masked_o          = clip_masked;
  assign injected_window_hit_flag_o = inj_flags[0];
  assign injected_clip_flag_o       = inj_flags[1];
  assign irq_source_summary_o       = cause_q;
  assign irq_o                      = irq_q;
  assign sequencer_state_o          = stat_q;
  assign averaging_progress_o       = avg_q;
  assign mux_switch_state_o         = mux_q;
endmodule

// file: logic/scan_irq_pkg.sv
// Types shared by the scan sequencer interrupt, trigger and status block
`include "scan_irq_regs.svh"
package scan_irq_pkg;
  // Main flag vector: done, overrun, clash, sw clash
  typedef logic [`MAIN_FLAGS-1:0] main_vec_t;
  typedef logic [`NUM_CHAN-1:0]   chan_vec_t;

  // One conversion or result event from the converter datapath
  typedef struct packed {
    logic                 valid;
    logic                 injected;
    logic [`CHAN_W-1:0]   chan;
    logic [`SAMPLE_W-1:0] code;
  } sample_evt_t;

  typedef struct packed {
    logic                 valid;
    logic                 injected;
    logic [`CHAN_W-1:0]   chan;
    logic [`RESULT_W-1:0] value;
  } result_evt_t;

  // Range window setup, thresholds in result format
  typedef struct packed {
    logic [1:0]           cond;
    logic [`RESULT_W-1:0] low;
    logic [`RESULT_W-1:0] high;
  } window_cfg_t;

  // Status view
  typedef struct packed {
    logic               busy;
    logic [`CHAN_W-1:0] active_channel_index;
    logic               neg_to_ref_switch_state;
  } sequencer_state_t;

  typedef struct packed {
    logic [`ACCU_W-1:0]    avg_accumulator_now;
    logic [`AVG_CNT_W-1:0] avg_samples_left;
  } averaging_progress_t;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_START,
    SEQ_BUSY
  } seq_state_t;
endpackage

// file: logic/scan_irq_regs.svh
// Constants for the scan sequencer interrupt, trigger and status block
`ifndef SCAN_IRQ_REGS_SVH
`define SCAN_IRQ_REGS_SVH
`define NUM_CHAN       16
`define CHAN_W         4
`define MAIN_FLAGS     4
`define BIT_DONE       0
`define BIT_OVERRUN    1
`define BIT_CLASH      2
`define BIT_SW_CLASH   3
`define SAMPLE_W       12
`define RESULT_W       16
`define ACCU_W         20
`define AVG_CNT_W      9
`define SWITCH_W       32
`define CODE_MIN       12'h000
`define CODE_MAX       12'hFFF
`define COND_BELOW     2'h0
`define COND_INSIDE    2'h1
`define COND_ABOVE     2'h2
`define COND_OUTSIDE   2'h3
`define CHAN_LAST      4'hF
`define ZERO_CHAN      4'h0
`endif

// file: logic/sticky_flags.sv
// Sticky flag vector with hardware set, force and write-one clear
`timescale 1ns/1ps
module sticky_flags #(
  parameter int W = 16
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] hw_set_i,
  input  wire logic [W-1:0] force_i,
  input  wire logic [W-1:0] clear_i,
  input  wire logic [W-1:0] mask_i,
  output logic      [W-1:0] flags_o,
  output logic      [W-1:0] masked_o
);
  logic [W-1:0] flags_q;   // Held flags
  logic [W-1:0] flags_d;   // Next flags
  logic [W-1:0] masked_q;  // Registered masked view

  // Set beats clear so an event in the clear cycle is not lost
  always_comb begin
    flags_d = (flags_q & ~clear_i) | hw_set_i | force_i;
  end

  // Masked view is registered so top outputs come from flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_q  <= '0;
      masked_q <= '0;
    end else begin
      flags_q  <= flags_d;
      masked_q <= flags_d & mask_i;
    end
  end

  assign flags_o  = flags_q;
  assign masked_o = masked_q;
endmodule

// file: verification/scan_irq_props_properties.sv
// Port checks for the scan sequencer interrupt and trigger block
`timescale 1ns/1ps
`include "scan_irq_regs.svh"
module scan_irq_props (
  input wire logic                           mclk_i,
  input wire logic                           rst_n_i,
  input wire logic                           enable_i,
  input wire logic                           continuous_i,
  input wire logic                           sw_scan_request_wr_i,
  input wire logic                           scan_complete_i,
  input wire scan_irq_pkg::main_vec_t        main_irq_mask_i,
  input wire logic                           start_sampling_o,
  input wire logic                           sw_scan_request_o,
  input wire scan_irq_pkg::main_vec_t        main_irq_flags_o,
  input wire scan_irq_pkg::main_vec_t        main_irq_masked_o,
  input wire scan_irq_pkg::chan_vec_t        window_irq_masked_o,
  input wire scan_irq_pkg::chan_vec_t        clip_irq_masked_o,
  input wire logic [`MAIN_FLAGS+1:0]         irq_source_summary_o,
  input wire logic                           irq_o,
  input wire scan_irq_pkg::sequencer_state_t sequencer_state_o
);
  import scan_irq_pkg::*;
  // One clock domain, so one clocking and one reset guard
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_done_set;
    scan_complete_i |=> main_irq_flags_o[`BIT_DONE];
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("done flag missing after scan end");
  // Mask is taken in the same cycle as the flag update
  property p_masked;
    main_irq_masked_o == (main_irq_flags_o & $past(main_irq_mask_i));
  endproperty
  a_masked: assert property (p_masked)
    else $error("main masked view wrong");
  property p_overrun;
    scan_complete_i && main_irq_flags_o[`BIT_DONE]
      |=> main_irq_flags_o[`BIT_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun flag missing");
  // Start command high proves the sequencer is not idle
  property p_clash;
    enable_i && !continuous_i && start_sampling_o && sw_scan_request_wr_i
      |=> main_irq_flags_o[`BIT_CLASH] && main_irq_flags_o[`BIT_SW_CLASH];
  endproperty
  a_clash: assert property (p_clash)
    else $error("clash flags missing");
  property p_sw_clear;
    scan_complete_i && !sw_scan_request_wr_i |=> !sw_scan_request_o;
  endproperty
  a_sw_clear: assert property (p_sw_clear)
    else $error("sw request kept after completion");
  // The cycle after a completion may hide a queued scan, so skip it
  property p_start;
    enable_i && sw_scan_request_wr_i && !start_sampling_o &&
      !sequencer_state_o.busy && !$past(scan_complete_i) |=> start_sampling_o;
  endproperty
  a_start: assert property (p_start)
    else $error("start command late");
  property p_irq;
    irq_o == $past(|main_irq_masked_o || |window_irq_masked_o ||
                   |clip_irq_masked_o);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt output wrong");
  property p_summary;
    irq_source_summary_o == $past({|clip_irq_masked_o,
                                   |window_irq_masked_o, main_irq_masked_o});
  endproperty
  a_summary: assert property (p_summary)
    else $error("cause summary wrong");
  c_scan: cover property (scan_complete_i ##1 main_irq_flags_o[`BIT_DONE]);
  c_over: cover property ($rose(main_irq_flags_o[`BIT_OVERRUN]));
  c_irq: cover property ($rose(irq_o));
endmodule
bind scan_irq_ctrl scan_irq_props props_i (.*);

// file: verification/testbench.sv
// Self-checking bench for the scan sequencer interrupt block
`timescale 1ns/1ps
`include "scan_irq_regs.svh"
module testbench;
  import scan_irq_pkg::*;
  logic mclk_i, rst_n_i, enable_i, continuous_i, sw_scan_request_wr_i;
  logic periph_trigger_i, start_ack_i, scan_complete_i, converting_i;
  logic neg_ref_sw_i, fire, start_sampling_o, sw_scan_request_o, irq_o;
  logic inj_window_clear_i, inj_window_force_i, inj_clip_clear_i;
  logic inj_clip_force_i, injected_window_hit_flag_o, injected_clip_flag_o;
  logic [`CHAN_W-1:0] chan_now_i;
  logic [`SWITCH_W-1:0] fw_mux_switches_i, mux_switch_state_o;
  logic [`MAIN_FLAGS+1:0] irq_source_summary_o;
  sample_evt_t sample_i;
  result_evt_t result_i;
  window_cfg_t window_cfg_i;
  averaging_progress_t avg_i, averaging_progress_o;
  main_vec_t main_irq_clear_i, main_irq_force_i, main_irq_mask_i;
  main_vec_t main_irq_flags_o, main_irq_masked_o;
  chan_vec_t window_irq_clear_i, window_irq_force_i, window_irq_mask_i;
  chan_vec_t clip_irq_clear_i, clip_irq_force_i, clip_irq_mask_i;
  chan_vec_t window_hit_flags_o, window_irq_masked_o, clip_flags_o;
  chan_vec_t clip_irq_masked_o;
  sequencer_state_t sequencer_state_o;
  int n_fail, cmp_count, irq_rises;
  scan_irq_ctrl dut (.*);
  trig_irq_model far_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fire_i(fire),
    .irq_i(irq_o), .trig_o(periph_trigger_i), .irq_rises_o(irq_rises));
  always #10 mclk_i = ~mclk_i;
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %0h got %0h", nm, exp, got);
    end
  endtask
  // Inputs change 1 ns after the edge, never on it
  task automatic step(int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic close_out;
    if (n_fail == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic pulse_sw;
    sw_scan_request_wr_i = 1'b1;
    step();
    sw_scan_request_wr_i = 1'b0;
  endtask
  task automatic ack_done;
    start_ack_i = 1'b1;
    step();
    start_ack_i = 1'b0;
    scan_complete_i = 1'b1;
    step();
    scan_complete_i = 1'b0;
  endtask
  // Write-one clear of every flag at once
  task automatic clr_all;
    {main_irq_clear_i, window_irq_clear_i, clip_irq_clear_i} = '1;
    {inj_window_clear_i, inj_clip_clear_i} = 2'h3;
    step();
    {main_irq_clear_i, window_irq_clear_i, clip_irq_clear_i} = '0;
    {inj_window_clear_i, inj_clip_clear_i} = 2'h0;
  endtask
  function automatic logic hit(logic [1:0] c, logic [15:0] v);
    case (c)
      2'h0: return v < 16'h0100;
      2'h1: return v >= 16'h0100 && v < 16'h0200;
      2'h2: return v >= 16'h0200;
      default: return v < 16'h0100 || v >= 16'h0200;
    endcase
  endfunction
  task automatic t_sw_scan;
    main_irq_mask_i = 4'hF;
    chan_now_i = 4'h9;
    pulse_sw();
    chk("start", 1, start_sampling_o);
    chk("swreq", 1, sw_scan_request_o);
    ack_done();
    chk("done", 1, main_irq_flags_o[`BIT_DONE]);
    chk("swreq_clr", 0, sw_scan_request_o);
    chk("masked", 1, main_irq_masked_o[`BIT_DONE]);
    step();
    chk("irq", 1, irq_o);
    pulse_sw();
    ack_done();
    chk("overrun", 3, main_irq_flags_o);
    clr_all();
    chk("cleared", 0, main_irq_flags_o);
  endtask
  // Triggers while busy wait, flag a clash, and run once afterwards
  task automatic t_clash;
    fire = 1'b1;
    step();
    fire = 1'b0;
    step();
    chk("periph_start", 1, start_sampling_o);
    pulse_sw();
    chk("sw_clash", 4'hC, main_irq_flags_o);
    clr_all();
    fire = 1'b1;
    step();
    fire = 1'b0;
    step();
    chk("hw_clash", 4'h4, main_irq_flags_o);
    chk("no_abort", 1, start_sampling_o);
    ack_done();
    step(2);
    chk("queued", 1, start_sampling_o);
    ack_done();
    step(2);
    chk("idle", 0, sequencer_state_o.busy);
    clr_all();
  endtask
  task automatic t_force;
    main_irq_mask_i = 4'h5;
    main_irq_force_i = 4'hF;
    {window_irq_force_i, clip_irq_force_i} = 32'h8001_0100;
    step();
    {window_irq_force_i, clip_irq_force_i} = '0;
    chk("forced", 4'hF, main_irq_flags_o);
    chk("mask5", 4'h5, main_irq_masked_o);
    chk("win_force", 16'h8001, window_hit_flags_o);
    chk("clip_force", 16'h0100, clip_flags_o);
    main_irq_clear_i = 4'hF;
    step();
    main_irq_force_i = '0;
    chk("set_wins", 4'hF, main_irq_flags_o);
    chk("cause", 6'h05, irq_source_summary_o);
    clr_all();
  endtask
  task automatic t_window;
    logic [15:0] v[4] = '{16'h00FF, 16'h0100, 16'h01FF, 16'h0200};
    chan_vec_t exp;
    window_cfg_i.low = 16'h0100;
    window_cfg_i.high = 16'h0200;
    for (int i = 0; i < 16; i++) begin
      window_cfg_i.cond = 2'(i >> 2);
      result_i = '{1'b1, 1'b0, 4'(i), v[i % 4]};
      exp[i] = hit(window_cfg_i.cond, v[i % 4]);
      step();
    end
    result_i = '{1'b1, 1'b1, 4'h0, 16'h0300};
    window_irq_mask_i = 16'h00F0;
    step();
    result_i = '0;
    chk("win", exp, window_hit_flags_o);
    chk("inj_win", 1, injected_window_hit_flag_o);
    chk("win_mask", exp & 16'h00F0, window_irq_masked_o);
    step();
    chk("cause_win", 6'h10, irq_source_summary_o);
    window_irq_mask_i = '0;
    clr_all();
  endtask
  task automatic t_clip;
    clip_irq_mask_i = 16'h0020;
    clip_irq_clear_i = 16'h0028;
    sample_i = '{1'b1, 1'b0, 4'h3, `CODE_MIN};
    step();
    clip_irq_clear_i = '0;
    sample_i = '{1'b1, 1'b0, 4'h5, `CODE_MAX};
    step();
    sample_i = '{1'b1, 1'b1, 4'h6, 12'h7FF};
    step();
    sample_i = '{1'b1, 1'b1, 4'h6, `CODE_MAX};
    chk("clip", 16'h0028, clip_flags_o);
    chk("inj_clip", 0, injected_clip_flag_o);
    chk("clip_mask", 16'h0020, clip_irq_masked_o);
    step();
    sample_i = '0;
    chk("inj_clip_on", 1, injected_clip_flag_o);
    chk("cause_clip", 6'h20, irq_source_summary_o);
    clip_irq_mask_i = '0;
    clr_all();
  endtask
  task automatic t_disable;
    pulse_sw();
    enable_i = 1'b0;
    step();
    chk("dis_clr", 0, sw_scan_request_o);
    pulse_sw();
    chk("dis_ignore", 0, sw_scan_request_o);
    enable_i = 1'b1;
    step(2);
  endtask
  task automatic t_continuous;
    continuous_i = 1'b1;
    step();
    chk("cont_start", 1, start_sampling_o);
    start_ack_i = 1'b1;
    step();
    start_ack_i = 1'b0;
    pulse_sw();
    chk("cont_noclash", 0, main_irq_flags_o[3:2]);
    scan_complete_i = 1'b1;
    step();
    scan_complete_i = 1'b0;
    chk("cont_swclr", 0, sw_scan_request_o);
    chk("cont_again", 1, start_sampling_o);
    continuous_i = 1'b0;
    ack_done();
    clr_all();
  endtask
  task automatic t_status;
    {neg_ref_sw_i, chan_now_i} = 5'h1C;
    avg_i = '{20'hABCDE, 9'h1A5};
    fw_mux_switches_i = 32'h8000_0001;
    converting_i = 1'b1;
    step();
    chk("neg_sw", 1, sequencer_state_o.neg_to_ref_switch_state);
    chk("chan", 4'hC, sequencer_state_o.active_channel_index);
    chk("busy", 1, sequencer_state_o.busy);
    chk("avg", 29'(avg_i), 29'(averaging_progress_o));
    chk("mux", 32'h8000_0001, mux_switch_state_o);
  endtask
  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    fire = 1'b0;
    {enable_i, continuous_i, sw_scan_request_wr_i, start_ack_i} = '0;
    {scan_complete_i, converting_i, chan_now_i, neg_ref_sw_i} = '0;
    {sample_i, result_i, window_cfg_i, avg_i, fw_mux_switches_i} = '0;
    {main_irq_clear_i, main_irq_force_i, main_irq_mask_i} = '0;
    {window_irq_clear_i, window_irq_force_i, window_irq_mask_i} = '0;
    {clip_irq_clear_i, clip_irq_force_i, clip_irq_mask_i} = '0;
    {inj_window_clear_i, inj_window_force_i} = '0;
    {inj_clip_clear_i, inj_clip_force_i} = '0;
    step(5);
    rst_n_i = 1'b1;
    enable_i = 1'b1;
    chk("rst_flags", 0, main_irq_flags_o);
    t_sw_scan();
    t_clash();
    t_force();
    t_window();
    t_clip();
    t_disable();
    t_continuous();
    t_status();
    chk("irq_seen", 1, irq_rises != 0);
    close_out();
  end
  // Whole run is about 70 cycles; cut off far beyond that
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule

// file: verification/trig_irq_model.sv
// Trigger routing and interrupt controller stand-in
`timescale 1ns/1ps
module trig_irq_model (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic fire_i,
  input  wire logic irq_i,
  output logic      trig_o,
  output int        irq_rises_o
);
  logic irq_q; // Last seen interrupt level
  // Route a request one cycle late; count interrupt rises
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_o      <= 1'b0;
      irq_q       <= 1'b0;
      irq_rises_o <= 0;
    end else begin
      trig_o <= fire_i;
      irq_q  <= irq_i;
      if (irq_i && !irq_q) begin
        irq_rises_o <= irq_rises_o + 1;
      end
    end
  end
endmodule
